// ===== rtl/pin_state_ctrl.sv
// top of the low-power pin state control
//
// Notes on behaviour
// (RQ1) reset pin low means reset asserted; high means reset released.
// (RQ2) in standby states level bit 0 keeps state, 1 forces hi-z, input low.
// (RQ3) a gated input presents logic low to internal logic.
// (RQ4) hi-z turns the pad output driver off.
// (RQ5) keep-previous holds configuration and drive from just before mode entry.
// (RQ6) keep-previous peripheral pins keep following a running peripheral.
// (RQ7) keep-previous port pins keep driving their last latched value.
// (RQ8) on deep standby entry flagged pins return to port operation.
// (RQ9) crystal output hi-z, input low in reset and when oscillator stopped.
// (RQ10) external clock pin with level 1 is hi-z; input low once oscillator stops.
// (RQ11) wake-up pin in deep standby with level 1 is hi-z, wake-up input on.
// (RQ12) port pin in standby with level 0 drives previous value, input low.
// (RQ13) unavailable selections have no effect in power-unstable and reset states.
// (RQ14) reset pin always has pull-up and input enabled.
// (RQ15) pins hi-z at power-on; hi-z with input on in reset held and internal.
// (RQ16) oscillator stopped in sub, low-speed, rtc, stop and deep standby modes.
// (RQ17) pad controls follow the encoded state input combinationally.
// (RQ18) any reset clears the level select bit to 0.
`default_nettype none
module pin_state_ctrl
  import pin_state_pkg::*;
#(
  parameter int N = pin_state_pkg::PIN_COUNT
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ext_reset_pin,
  input wire pin_state_pkg::pwr_state_e i_pwr_state,
  input wire logic i_spl_wr,
  input wire logic i_spl_wdata,
  input wire pin_state_pkg::pin_cfg_s [N-1:0] i_pin_cfg,
  input wire logic [N-1:0] i_pad_in,
  output pin_state_pkg::pad_ctrl_s [N-1:0] o_pad,
  output logic [N-1:0] o_core_in,
  output logic o_rst_pad_pull_up,
  output logic o_rst_pad_in_en,
  output logic o_xout_drive_en_n,
  output logic o_xout_in_en,
  output logic o_osc_stopped,
  output pin_state_pkg::mode_class_e o_class,
  output logic o_standby_pin_level_select
);
  import pin_state_pkg::*;

  // ************************************************************
  // state of the module
  // ************************************************************
  // phase only steers the snapshot; the pads never wait on it
  typedef struct packed {
    logic [1:0] rst_sync;
    logic standby_pin_level_select;
    phase_e phase;
    pin_keep_s [N-1:0] keep;
    logic [N-1:0] in_meta;
    logic [N-1:0] in_sync;
    logic [N-1:0] core_in;
  } state_s;

  state_s state_q;
  state_s state_d;
  mode_class_e cls;
  logic osc_stopped;
  logic rst_released;
  pad_ctrl_s [N-1:0] pad;

  // ************************************************************
  // decoding functions
  // ************************************************************
  // main oscillator stopped in these states
  function automatic logic osc_is_stopped(input pwr_state_e ps);
    case (ps)
      PS_SUB_RUN, PS_LCR_RUN, PS_SUB_SLEEP, PS_LCR_SLEEP,
      PS_SUB_TIMER, PS_LCR_TIMER, PS_RTC, PS_STOP,
      PS_DSTB_RTC, PS_DSTB_STOP: osc_is_stopped = LEVEL_HIGH; // see (RQ16)
      default: osc_is_stopped = LEVEL_LOW;
    endcase
  endfunction

  // behaviour class from state and reset pin level
  function automatic mode_class_e classify(input pwr_state_e ps, input logic released);
    if (ps == PS_POR) begin
      classify = CL_POR;
    end else if (!released) begin
      classify = CL_XRST; // see (RQ1)
    end else begin
      case (ps)
        PS_IRST: classify = CL_IRST;
        PS_RUN, PS_SLEEP, PS_SUB_RUN, PS_LCR_RUN,
        PS_SUB_SLEEP, PS_LCR_SLEEP: classify = CL_RUN;
        PS_TIMER, PS_SUB_TIMER, PS_LCR_TIMER,
        PS_RTC, PS_STOP: classify = CL_STBY;
        PS_DSTB_RTC, PS_DSTB_STOP: classify = CL_DSTB;
        PS_DSTB_RETURN: classify = CL_DRET;
        default: classify = CL_POR;
      endcase
    end
  endfunction

  // reset classes: pads fall back to the default reset behaviour
  function automatic logic is_reset_class(input mode_class_e c);
    is_reset_class = (c == CL_POR) || (c == CL_XRST) || (c == CL_IRST);
  endfunction

  // run classes: pads follow the live configuration
  function automatic logic is_run_class(input mode_class_e c);
    is_run_class = (c == CL_RUN) || (c == CL_DRET);
  endfunction

  // ************************************************************
  // class and oscillator decode
  // ************************************************************
  // pad controls follow the state input with no register in the way
  assign rst_released = state_q.rst_sync[1]; // see (RQ1)
  assign cls = classify(i_pwr_state, rst_released); // see (RQ17)
  assign osc_stopped = osc_is_stopped(i_pwr_state);

  // ************************************************************
  // per-pin decode
  // ************************************************************
  // one decode cell per multiplexed pin
  generate
    for (genvar g = 0; g < N; g++) begin : g_pin
      pin_state_cell u_cell (
        .i_class(cls),
        .i_spl(state_q.standby_pin_level_select),
        .i_osc_stopped(osc_stopped),
        .i_cfg(i_pin_cfg[g]),
        .i_keep(state_q.keep[g]),
        .o_pad(pad[g])
      );
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_d = state_q;
    // reset pin synchroniser, first stage read only by the second
    state_d.rst_sync = {state_q.rst_sync[0], i_ext_reset_pin};
    state_d.in_meta = i_pad_in;
    state_d.in_sync = state_q.in_meta;
    // level select bit written by software side
    if (i_spl_wr) begin
      state_d.standby_pin_level_select = i_spl_wdata;
    end
    // any reset state drops the level bit back to keep-previous, over a write
    if (is_reset_class(cls)) begin
      state_d.standby_pin_level_select = SPL_RESET; // see (RQ18)
    end
    // phase tracker and snapshot of the pre-entry configuration
    case (state_q.phase)
      PH_RESET: begin
        if (is_run_class(cls)) begin
          state_d.phase = PH_LIVE;
        end
      end
      PH_LIVE: begin
        if (cls == CL_STBY || cls == CL_DSTB) begin
          state_d.phase = PH_HELD; // snapshot now frozen
        end else if (is_reset_class(cls)) begin
          state_d.phase = PH_RESET;
        end
      end
      PH_HELD: begin
        if (is_run_class(cls)) begin
          state_d.phase = PH_LIVE;
        end else if (is_reset_class(cls)) begin
          state_d.phase = PH_RESET;
        end
      end
      default: begin
        state_d.phase = PH_RESET;
      end
    endcase
    // the snapshot follows the live config while the next phase is live, so the
    // value driven in standby is the one of the last run cycle before entry
    for (int k = 0; k < N; k++) begin
      if (state_d.phase == PH_LIVE) begin
        state_d.keep[k].gpio_out = i_pin_cfg[k].gpio_out; // see (RQ5) (RQ7)
        state_d.keep[k].gpio_drive = i_pin_cfg[k].gpio_drive;
        state_d.keep[k].pull_up = i_pin_cfg[k].pull_up;
      end
      // gated input reads low to internal logic
      state_d.core_in[k] = pad[k].in_en & state_q.in_sync[k]; // see (RQ3)
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= '0;
      state_q.standby_pin_level_select <= SPL_RESET; // see (RQ18)
      state_q.phase <= PH_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_pad = pad;
  // core input lags the pad by two sync flops and the gate register
  assign o_core_in = state_q.core_in;
  // reset pin pull-up and input are never removed
  assign o_rst_pad_pull_up = LEVEL_HIGH; // see (RQ14)
  assign o_rst_pad_in_en = LEVEL_HIGH; // see (RQ14)
  // crystal output: hi-z with input low in reset or with oscillator off
  assign o_xout_drive_en_n = is_reset_class(cls)
                             || osc_stopped; // see (RQ9)
  assign o_xout_in_en = !o_xout_drive_en_n; // see (RQ9)
  assign o_osc_stopped = osc_stopped;
  assign o_class = cls;
  assign o_standby_pin_level_select = state_q.standby_pin_level_select;
endmodule // pin_state_ctrl
`default_nettype wire

// ===== inc/pin_state_pkg.sv
// package: encodings and carriers for the low-power pin state control
`default_nettype none
package pin_state_pkg;
  // ************************************************************
  // sizes and reset values
  // ************************************************************
  localparam int PIN_COUNT = 8;
  localparam logic SPL_RESET = 1'b0;
  localparam logic LEVEL_LOW = 1'b0;
  localparam logic LEVEL_HIGH = 1'b1;

  // ************************************************************
  // operating state reported by the power-mode controller
  // ************************************************************
  typedef enum logic [3:0] {
    PS_POR = 4'h0,
    PS_IRST = 4'h1,
    PS_RUN = 4'h2,
    PS_SLEEP = 4'h3,
    PS_SUB_RUN = 4'h4,
    PS_LCR_RUN = 4'h5,
    PS_SUB_SLEEP = 4'h6,
    PS_LCR_SLEEP = 4'h7,
    PS_TIMER = 4'h8,
    PS_SUB_TIMER = 4'h9,
    PS_LCR_TIMER = 4'hA,
    PS_RTC = 4'hB,
    PS_STOP = 4'hC,
    PS_DSTB_RTC = 4'hD,
    PS_DSTB_STOP = 4'hE,
    PS_DSTB_RETURN = 4'hF
  } pwr_state_e;

  // pin behaviour class derived from state and reset pin
  typedef enum logic [6:0] {
    CL_POR = 7'h01,
    CL_XRST = 7'h02,
    CL_IRST = 7'h04,
    CL_RUN = 7'h08,
    CL_STBY = 7'h10,
    CL_DSTB = 7'h20,
    CL_DRET = 7'h40
  } mode_class_e;

  // internal phase tracker
  typedef enum logic [2:0] {
    PH_RESET = 3'h1,
    PH_LIVE = 3'h2,
    PH_HELD = 3'h4
  } phase_e;

  // function a pin is assigned to
  typedef enum logic [2:0] {
    FN_GPIO = 3'h0,
    FN_PERIPH = 3'h1,
    FN_WAKEUP = 3'h2,
    FN_EXTINT = 3'h3,
    FN_EXTCLK = 3'h4
  } pin_func_e;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    pin_func_e func;
    logic dstb_to_gpio;
    logic pull_up;
    logic gpio_out;
    logic gpio_drive;
    logic periph_out;
    logic periph_drive;
  } pin_cfg_s;

  typedef struct packed {
    logic gpio_out;
    logic gpio_drive;
    logic pull_up;
  } pin_keep_s;

  typedef struct packed {
    logic drive_en_n;
    logic out;
    logic pull_up;
    logic in_en;
  } pad_ctrl_s;
endpackage
`default_nettype wire

// ===== rtl/pin_state_cell.sv
// per-pin decode of pad drive, pull-up and input gating
`default_nettype none
module pin_state_cell
  import pin_state_pkg::*;
(
  input wire pin_state_pkg::mode_class_e i_class,
  input wire logic i_spl,
  input wire logic i_osc_stopped,
  input wire pin_state_pkg::pin_cfg_s i_cfg,
  input wire pin_state_pkg::pin_keep_s i_keep,
  output pin_state_pkg::pad_ctrl_s o_pad
);
  import pin_state_pkg::*;
  logic gpio_path;
  logic periph_live;

  // ************************************************************
  // pin behaviour by class
  // ************************************************************
  always_comb begin
    gpio_path = (i_cfg.func == FN_GPIO) || (i_class == CL_DSTB && i_cfg.dstb_to_gpio); // see (RQ8)
    periph_live = (i_cfg.func == FN_PERIPH) && !gpio_path;
    o_pad.drive_en_n = LEVEL_HIGH; // hi-z by default
    o_pad.out = LEVEL_LOW;
    o_pad.pull_up = LEVEL_LOW;
    o_pad.in_en = LEVEL_LOW;
    case (i_class)
      CL_POR: begin
        o_pad.in_en = LEVEL_LOW; // see (RQ15) (RQ13) (RQ4)
      end
      CL_XRST, CL_IRST: begin
        o_pad.in_en = LEVEL_HIGH; // see (RQ15) (RQ13) (RQ1)
      end
      CL_RUN, CL_DRET: begin
        o_pad.pull_up = i_cfg.pull_up;
        o_pad.in_en = LEVEL_HIGH;
        if (i_cfg.func == FN_PERIPH && !(i_class == CL_DRET && i_cfg.dstb_to_gpio)) begin
          o_pad.drive_en_n = !i_cfg.periph_drive;
          o_pad.out = i_cfg.periph_out;
        end else begin
          o_pad.drive_en_n = !i_cfg.gpio_drive;
          o_pad.out = i_cfg.gpio_out;
        end
      end
      CL_STBY, CL_DSTB: begin
        if (!i_spl) begin
          // keep previous state
          o_pad.pull_up = i_keep.pull_up; // see (RQ5)
          if (periph_live) begin
            o_pad.drive_en_n = !i_cfg.periph_drive; // see (RQ6)
            o_pad.out = i_cfg.periph_out;
            o_pad.in_en = LEVEL_HIGH;
          end else begin
            o_pad.drive_en_n = !i_keep.gpio_drive; // see (RQ7) (RQ12)
            o_pad.out = i_keep.gpio_out;
            o_pad.in_en = LEVEL_LOW; // see (RQ12) (RQ3)
          end
          if (i_cfg.func == FN_EXTINT && i_class == CL_STBY) begin
            o_pad.in_en = LEVEL_HIGH;
          end
          if (i_cfg.func == FN_WAKEUP && i_class == CL_DSTB) begin
            o_pad.in_en = LEVEL_HIGH;
          end
          if (i_cfg.func == FN_EXTCLK && i_class == CL_STBY) begin
            o_pad.in_en = !i_osc_stopped;
          end
        end else begin
          // forced hi-z, input held low unless the function keeps it
          o_pad.drive_en_n = LEVEL_HIGH; // see (RQ2) (RQ4)
          o_pad.in_en = LEVEL_LOW; // see (RQ2) (RQ3)
          if (i_cfg.func == FN_EXTCLK && i_class == CL_STBY) begin
            o_pad.in_en = !i_osc_stopped; // see (RQ10)
          end
          if (i_cfg.func == FN_WAKEUP && i_class == CL_DSTB) begin
            o_pad.in_en = LEVEL_HIGH; // see (RQ11)
          end
          if (i_cfg.func == FN_EXTINT && i_class == CL_STBY) begin
            o_pad.pull_up = i_keep.pull_up;
            o_pad.in_en = LEVEL_HIGH;
          end
        end
      end
      default: begin
        o_pad.in_en = LEVEL_LOW;
      end
    endcase
  end
endmodule // pin_state_cell
`default_nettype wire

// ===== testbench/pin_state_ctrl_properties.sv
// checker: port properties of the pin state control
`default_nettype none
module pin_state_ctrl_properties
  import pin_state_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ext_reset_pin,
  input wire pin_state_pkg::pwr_state_e i_pwr_state,
  input wire logic i_spl_wr,
  input wire logic i_spl_wdata,
  input wire pin_state_pkg::pin_cfg_s [N-1:0] i_pin_cfg,
  input wire pin_state_pkg::pad_ctrl_s [N-1:0] o_pad,
  input wire logic [N-1:0] o_core_in,
  input wire logic o_rst_pad_pull_up,
  input wire logic o_rst_pad_in_en,
  input wire logic o_xout_drive_en_n,
  input wire logic o_xout_in_en,
  input wire logic o_osc_stopped,
  input wire pin_state_pkg::mode_class_e o_class,
  input wire logic o_standby_pin_level_select
);
  logic [N-1:0] dn_v;
  logic [N-1:0] in_v;
  // gather drive and input enables of all pads
  always_comb begin
    for (int k = 0; k < N; k++) begin
      dn_v[k] = o_pad[k].drive_en_n;
      in_v[k] = o_pad[k].in_en;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  rst_pin_on_a: assert property (o_rst_pad_pull_up && o_rst_pad_in_en)
    else $error("reset pin pull-up or input off");
  osc_decode_a: assert property (
    o_osc_stopped == (i_pwr_state inside {PS_SUB_RUN, PS_LCR_RUN, PS_SUB_SLEEP,
    PS_LCR_SLEEP, PS_SUB_TIMER, PS_LCR_TIMER, PS_RTC, PS_STOP, PS_DSTB_RTC, PS_DSTB_STOP}))
    else $error("oscillator stop decode wrong");
  xout_off_a: assert property (
    (o_osc_stopped || o_class inside {CL_POR, CL_XRST, CL_IRST})
    |-> o_xout_drive_en_n && !o_xout_in_en) else $error("crystal output not off");
  xrst_seen_a: assert property (
    (!i_ext_reset_pin && i_pwr_state != PS_POR) [*3] |-> o_class == CL_XRST)
    else $error("reset pin low not seen");
  por_hiz_a: assert property (
    i_pwr_state == PS_POR |-> o_class == CL_POR && (&dn_v) && in_v == '0)
    else $error("pads not off at power-on");
  rst_hiz_a: assert property (
    o_class inside {CL_XRST, CL_IRST} |-> (&dn_v) && (&in_v))
    else $error("pads not hi-z with input in reset");
  gate_low_a: assert property (
    in_v != '1 |=> (o_core_in & ~$past(in_v)) == '0) else $error("gated input not low");
  level_hold_a: assert property (
    !i_spl_wr && !(o_class inside {CL_POR, CL_XRST, CL_IRST})
    |=> $stable(o_standby_pin_level_select)) else $error("level bit moved");
  level_clear_a: assert property (
    o_class inside {CL_POR, CL_XRST, CL_IRST} |=> !o_standby_pin_level_select)
    else $error("level bit not cleared in reset");
  level_take_a: assert property (
    i_spl_wr && !(o_class inside {CL_POR, CL_XRST, CL_IRST})
    |=> o_standby_pin_level_select == $past(i_spl_wdata))
    else $error("level bit write lost");
  stby_hiz_a: assert property (
    o_class inside {CL_STBY, CL_DSTB} && o_standby_pin_level_select
    && i_pin_cfg[0].func == FN_GPIO |-> o_pad[0].drive_en_n && !o_pad[0].in_en)
    else $error("standby port pin not hi-z");
endmodule // pin_state_ctrl_properties
bind pin_state_ctrl pin_state_ctrl_properties #(.N(N)) pin_state_ctrl_properties_inst (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ext_reset_pin(i_ext_reset_pin),
  .i_pwr_state(i_pwr_state), .i_spl_wr(i_spl_wr), .i_spl_wdata(i_spl_wdata),
  .i_pin_cfg(i_pin_cfg), .o_pad(o_pad), .o_core_in(o_core_in),
  .o_rst_pad_pull_up(o_rst_pad_pull_up), .o_rst_pad_in_en(o_rst_pad_in_en),
  .o_xout_drive_en_n(o_xout_drive_en_n), .o_xout_in_en(o_xout_in_en),
  .o_osc_stopped(o_osc_stopped), .o_class(o_class),
  .o_standby_pin_level_select(o_standby_pin_level_select));
`default_nettype wire

// ===== testbench/board_net_model.sv
// board nets model: pad input levels seen by the block
`default_nettype none
module board_net_model
  import pin_state_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input wire logic i_core_clk,
  input wire pin_state_pkg::pad_ctrl_s [N-1:0] i_pad,
  output logic [N-1:0] o_pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [N-1:0] float_q = '0;
  // an undriven net without pull-up wanders every cycle
  always_ff @(posedge i_core_clk) begin
    float_q <= ~float_q;
  end
  // net level: pad driver first, then pull-up, then wander
  always_comb begin
    for (int k = 0; k < N; k++) begin
      if (!i_pad[k].drive_en_n) begin
        o_pad_in[k] = i_pad[k].out;
      end else if (i_pad[k].pull_up) begin
        o_pad_in[k] = 1'b1;
      end else begin
        o_pad_in[k] = float_q[k];
      end
    end
  end
endmodule // board_net_model
`default_nettype wire

// ===== testbench/low_power_pin_state_control_tb.sv
// testbench: pin behaviour across reset, run and standby states
`default_nettype none
module low_power_pin_state_control_tb
  import pin_state_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NP = 5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic xrst = 1'b1;
  logic wr = 1'b0;
  logic wd = 1'b0;
  pwr_state_e st = PS_POR;
  pin_cfg_s [NP-1:0] cfg = '0;
  logic [NP-1:0] pin_in;
  pad_ctrl_s [NP-1:0] pad;
  logic [NP-1:0] core_in;
  logic xdn;
  logic xin;
  logic standby_pin_level_select;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  pin_state_ctrl #(.N(NP)) pin_state_ctrl_inst (.i_core_clk(clk), .i_resetn(rstn),
    .i_ext_reset_pin(xrst), .i_pwr_state(st), .i_spl_wr(wr), .i_spl_wdata(wd),
    .i_pin_cfg(cfg), .i_pad_in(pin_in), .o_pad(pad), .o_core_in(core_in),
    .o_rst_pad_pull_up(), .o_rst_pad_in_en(), .o_xout_drive_en_n(xdn),
    .o_xout_in_en(xin), .o_osc_stopped(), .o_class(), .o_standby_pin_level_select(standby_pin_level_select));
  board_net_model #(.N(NP)) board_net_model_inst (.i_core_clk(clk), .i_pad(pad),
    .o_pad_in(pin_in));
  // free-running clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic results();
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // compare {drive_en_n, out, in_en} of one pad under a mask
  task automatic pc(input int i, input logic [2:0] exp, input logic [2:0] m);
    chk({pad[i].drive_en_n, pad[i].out, pad[i].in_en} & m, exp);
  endtask
  task automatic t_por();
    repeat (3) @(posedge clk);
    #1;
    pc(0, 3'b100, 3'b101);
    pc(3, 3'b100, 3'b101);
    chk(pad[2].pull_up, 1'b0);
  endtask
  task automatic t_rst();
    @(posedge clk);
    st <= PS_IRST;
    xrst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    pc(0, 3'b101, 3'b101);
    chk({xdn, xin}, 2'b10);
    chk(pad[2].pull_up, 1'b0);
    // a level write while the reset pin is held must not stick
    @(posedge clk);
    wr <= 1'b1;
    wd <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    xrst <= 1'b1;
    #1;
    chk(standby_pin_level_select, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    pc(0, 3'b101, 3'b101);
  endtask
  task automatic t_stby();
    @(posedge clk);
    st <= PS_RUN;
    repeat (5) @(posedge clk);
    #1;
    pc(0, 3'b011, 3'b111);
    chk(core_in[0], 1'b1);
    chk(pad[2].pull_up, 1'b1);
    chk({xdn, xin}, 2'b01);
    @(posedge clk);
    st <= PS_STOP;
    cfg[0].gpio_out <= 1'b0;
    cfg[1].gpio_out <= 1'b0;
    cfg[1].periph_out <= 1'b1;
    cfg[2].pull_up <= 1'b0;
    @(posedge clk);
    #1;
    pc(0, 3'b010, 3'b111);
    pc(1, 3'b010, 3'b110);
    chk(core_in[0], 1'b0);
    chk(pad[2].pull_up, 1'b1);
    pc(4, 3'b101, 3'b101);
    chk({xdn, xin}, 2'b10);
  endtask
  task automatic t_spl();
    @(posedge clk);
    wr <= 1'b1;
    wd <= 1'b1;
    st <= PS_TIMER;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    chk(standby_pin_level_select, 1'b1);
    pc(0, 3'b100, 3'b101);
    pc(3, 3'b101, 3'b101);
    pc(4, 3'b101, 3'b101);
    @(posedge clk);
    st <= PS_STOP;
    #1;
    pc(3, 3'b100, 3'b101);
    @(posedge clk);
    st <= PS_DSTB_STOP;
    #1;
    pc(2, 3'b101, 3'b101);
    @(posedge clk);
    wr <= 1'b1;
    wd <= 1'b0;
    cfg[1].periph_out <= 1'b0;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    pc(1, 3'b010, 3'b110);
    @(posedge clk);
    st <= PS_DSTB_RETURN;
    #1;
    pc(1, 3'b000, 3'b110);
  endtask
  task automatic t_clear();
    @(posedge clk);
    wr <= 1'b1;
    wd <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    chk(standby_pin_level_select, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(standby_pin_level_select, 1'b0);
    pc(0, 3'b101, 3'b101);
    repeat (3) @(posedge clk);
    #1;
    pc(0, 3'b001, 3'b111);
  endtask
  // pin 0 port, 1 peripheral returning to port, 2 wake-up, 3 clock input, 4 interrupt
  initial begin
    cfg[0].gpio_drive = 1'b1;
    cfg[0].gpio_out = 1'b1;
    cfg[1].func = FN_PERIPH;
    cfg[1].dstb_to_gpio = 1'b1;
    cfg[1].gpio_drive = 1'b1;
    cfg[1].gpio_out = 1'b1;
    cfg[1].periph_drive = 1'b1;
    cfg[2].func = FN_WAKEUP;
    cfg[2].pull_up = 1'b1;
    cfg[3].func = FN_EXTCLK;
    cfg[4].func = FN_EXTINT;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_por();
    t_rst();
    t_stby();
    t_spl();
    t_clear();
    results();
  end
endmodule // low_power_pin_state_control_tb
`default_nettype wire
